// ---- logic/pmg_params.svh ----
// Constants for the peripheral module gate: offsets, bit positions, masks, timing.
// Assumes a 200 MHz system clock and a 4-bit Avalon-MM byte address.
`ifndef PMG_PARAMS_SVH
`define PMG_PARAMS_SVH

`define PMG_NUM_MODS 16
`define PMG_ADDR_W 4
`define PMG_WAKE_W 8

// Register byte offsets
`define PMG_OFF_CTRL0 4'h0
`define PMG_OFF_CTRL1 4'h4
`define PMG_OFF_CTRL2 4'h8
`define PMG_OFF_STAT 4'hC

// Implemented bits per control register, reset value
`define PMG_CTRL0_MASK 8'hC7
`define PMG_CTRL1_MASK 8'hFF
`define PMG_CTRL2_MASK 8'h66
`define PMG_CTRL_RST 8'h00

// Control register 0 bit positions
`define PMG_B_NET 7
`define PMG_B_FVR 6
`define PMG_B_NVM 2
`define PMG_B_CLKR 1
`define PMG_B_IOC 0
// Control register 1: timers at bits 6..0, oscillator at bit 7
`define PMG_B_NCO 7
`define PMG_NUM_TIMERS 7
// Control register 2 bit positions
`define PMG_B_DAC 6
`define PMG_B_ADC 5
`define PMG_B_CMP2 2
`define PMG_B_CMP1 1

// Module slot indices on the gated vectors
`define PMG_M_IOC 0
`define PMG_M_CLKR 1
`define PMG_M_NVM 2
`define PMG_M_FVR 3
`define PMG_M_TMR0 4
`define PMG_M_NCO 11
`define PMG_M_CMP1 12
`define PMG_M_CMP2 13
`define PMG_M_ADC 14
`define PMG_M_DAC 15

// Slots fed from the gated system clock network
`define PMG_SYSCLK_USERS 16'h0FF2

// Timing
`define PMG_CLK_PERIOD_PS 5000
`define PMG_INSTR_CLKS 4
`define PMG_NVM_WAKE_NS 1000
`define PMG_NVM_WAKE_CLKS ((`PMG_NVM_WAKE_NS * 1000) / `PMG_CLK_PERIOD_PS)

// Avalon response codes and bus widths
`define PMG_RESP_OKAY 2'h0
`define PMG_RESP_DECERR 2'h3
`define PMG_BUS_W 32
`define PMG_SFR_W 8

`endif

// ---- logic/pmg_pkg.sv ----
// Types for the peripheral module gate.
// Assumes pmg_params.svh is on the include path.
`include "pmg_params.svh"

package pmg_pkg;

  // Three disable control registers
  typedef struct packed {
    logic [7:0] c2;
    logic [7:0] c1;
    logic [7:0] c0;
  } pmg_ctrl_t;

  // What the peripherals hand back to the gate
  typedef struct packed {
    logic [`PMG_NUM_MODS-1:0] ctrl;
    logic [`PMG_NUM_MODS-1:0] dout;
    logic [`PMG_NUM_MODS-1:0][`PMG_SFR_W-1:0] sfr_rdata;
  } pmg_mod_in_t;

  // What the gate drives toward the peripherals
  typedef struct packed {
    logic [`PMG_NUM_MODS-1:0] clk_en;
    logic [`PMG_NUM_MODS-1:0] rst;
    logic [`PMG_NUM_MODS-1:0] ctrl;
    logic [`PMG_NUM_MODS-1:0] aout_en;
    logic [`PMG_NUM_MODS-1:0] sfr_wr;
  } pmg_mod_out_t;

  // Wake state of one gated slot
  typedef enum logic [1:0] {
    PMG_OFF,
    PMG_WAKE,
    PMG_RUN
  } pmg_cell_mode_t;

  typedef struct packed {
    pmg_cell_mode_t mode;
    logic [`PMG_WAKE_W-1:0] cnt;
  } pmg_cell_st_t;

  // Whole state of the top module
  typedef struct packed {
    pmg_ctrl_t ctrl;
    logic ack;
    logic [`PMG_BUS_W-1:0] rdata;
    logic [1:0] resp;
    logic [`PMG_SFR_W-1:0] sfr_rdata;
    logic [`PMG_NUM_MODS-1:0] dout;
    logic [`PMG_SFR_W-1:0] ee_rdata;
  } pmg_state_t;

endpackage

// ---- logic/pmg_gate_cell.sv ----
// One gated peripheral slot: holds reset while disabled, then counts a wake delay.
// Assumes off is a registered level from the control registers.
`timescale 1ns/1ps
`include "pmg_params.svh"

module pmg_gate_cell import pmg_pkg::*; #(
  parameter logic [`PMG_WAKE_W-1:0] WAKE_CLKS = `PMG_WAKE_W'(`PMG_INSTR_CLKS)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic off,
  output logic rst_hold,
  output logic active
);

  pmg_cell_st_t st_r;
  pmg_cell_st_t st_nxt;

  // Off forces the slot back to the start; clearing it starts the wake count
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.mode)
      PMG_OFF: begin
        if (!off) begin
          // The cycle spent here counts toward the wake window, so load one less
          st_nxt.mode = PMG_WAKE; // RULE6
          st_nxt.cnt = WAKE_CLKS - `PMG_WAKE_W'(1); // RULE7
        end
      end
      PMG_WAKE: begin
        if (off) begin
          st_nxt.mode = PMG_OFF;
        end else if (st_r.cnt <= `PMG_WAKE_W'(1)) begin
          st_nxt.mode = PMG_RUN; // RULE7
        end else begin
          st_nxt.cnt = st_r.cnt - `PMG_WAKE_W'(1);
        end
      end
      PMG_RUN: begin
        if (off) begin
          st_nxt.mode = PMG_OFF;
        end
      end
      // The fourth code of the mode field is unused; fall back to the held state
      default: begin
        st_nxt = '{mode: PMG_OFF, cnt: '0};
      end
    endcase
  end

  // Slots leave reset running, nothing is disabled after any reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{mode: PMG_RUN, cnt: '0}; // RULE1
    end else begin
      st_r <= st_nxt;
    end
  end

  // Reset stays on while off and through the wake window, so registers return at POR values
  assign rst_hold = srst || off || (st_r.mode != PMG_RUN); // RULE3 RULE6
  assign active = (st_r.mode == PMG_RUN) && !off;

endmodule // pmg_gate_cell

// ---- logic/pmg_top.sv ----
// Peripheral module gate: three disable registers on Avalon-MM and per-slot gating.
// Assumes peripherals use clk_en as a glitch-free clock gate enable and rst as a sync reset.
//
// Function
// (RULE1) Every disable bit clears on any reset; all modules start enabled.
// (RULE2) A disabled module gets no clock enable and no control inputs.
// (RULE3) A disabled module is held in reset while its bit is set.
// (RULE4) Disabled module: register writes dropped, register reads return zero.
// (RULE5) Disabled module: analog outputs off, digital outputs forced low.
// (RULE6) Clearing the bit brings the module back in its reset state.
// (RULE7) Re-enabled module may take one instruction cycle to become active.
// (RULE8) Software should wait one instruction before touching a re-enabled module.
// (RULE9) Control 0 bit 7 stops the system clock network to its users.
// (RULE10) Control 0 bit 6 disables voltage reference, bit 1 clock output.
// (RULE11) Control 0 bit 0 disables pin-change interrupt logic of all ports.
// (RULE12) Memory-off bit blocks EEPROM access, control writes; indirect reads give zero.
// (RULE13) Caller may wait up to 1 us after memory re-enable.
// (RULE14) Control 1 bit 7 disables oscillator, bits 6..0 timers six..zero.
// (RULE15) Control 2 bits 6,5,2,1 disable DAC, ADC, comparator two, one.
// (RULE16) Unimplemented bits read zero and ignore writes.
// (RULE17) Implemented bits are read-write and reset to zero on all resets.
// (RULE18) Disable registers stay clocked and reachable whatever they hold.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "pmg_params.svh"

module pmg_top import pmg_pkg::*; #(
  parameter logic [`PMG_NUM_MODS-1:0] SYSCLK_USERS = `PMG_SYSCLK_USERS,
  parameter int INSTR_CLKS = `PMG_INSTR_CLKS,
  parameter int NVM_WAKE_CLKS = `PMG_NVM_WAKE_CLKS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`PMG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`PMG_BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [`PMG_BUS_W-1:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic [`PMG_NUM_MODS-1:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [`PMG_SFR_W-1:0] sfr_rdata,
  input wire pmg_mod_in_t mod_in,
  output pmg_mod_out_t mod_out,
  output logic [`PMG_NUM_MODS-1:0] mod_dout,
  output logic [`PMG_NUM_MODS-1:0] mod_active,
  output logic periph_clock_net_off,
  input wire logic ee_rd_in,
  input wire logic ee_wr_in,
  input wire logic [`PMG_SFR_W-1:0] ee_rdata_in,
  output logic ee_rd,
  output logic ee_wr,
  output logic [`PMG_SFR_W-1:0] ee_rdata,
  output logic nonvolatile_mem_off
);

  pmg_state_t st_r;
  pmg_state_t st_nxt;

  logic [`PMG_NUM_MODS-1:0] mod_off;
  logic [`PMG_NUM_MODS-1:0] rst_hold;
  logic [`PMG_NUM_MODS-1:0] live;
  logic [`PMG_NUM_MODS-1:0] sfr_ok;
  logic [`PMG_NUM_MODS-1:0] clk_open;
  logic [`PMG_SFR_W-1:0] sfr_mux;
  logic bus_req;
  logic hit_ctrl0;
  logic hit_ctrl1;
  logic hit_ctrl2;
  logic hit_stat;
  logic hit_any;
  logic lane0_wr;

  // Disable bit of each slot, taken from the three control registers
  always_comb begin
    mod_off = '0;
    mod_off[`PMG_M_IOC] = st_r.ctrl.c0[`PMG_B_IOC]; // RULE11
    mod_off[`PMG_M_CLKR] = st_r.ctrl.c0[`PMG_B_CLKR]; // RULE10
    mod_off[`PMG_M_NVM] = st_r.ctrl.c0[`PMG_B_NVM]; // RULE12
    mod_off[`PMG_M_FVR] = st_r.ctrl.c0[`PMG_B_FVR]; // RULE10
    mod_off[`PMG_M_TMR0 +: `PMG_NUM_TIMERS] = st_r.ctrl.c1[`PMG_NUM_TIMERS-1:0]; // RULE14
    mod_off[`PMG_M_NCO] = st_r.ctrl.c1[`PMG_B_NCO]; // RULE14
    mod_off[`PMG_M_CMP1] = st_r.ctrl.c2[`PMG_B_CMP1]; // RULE15
    mod_off[`PMG_M_CMP2] = st_r.ctrl.c2[`PMG_B_CMP2]; // RULE15
    mod_off[`PMG_M_ADC] = st_r.ctrl.c2[`PMG_B_ADC]; // RULE15
    mod_off[`PMG_M_DAC] = st_r.ctrl.c2[`PMG_B_DAC]; // RULE15
  end

  // Network-off bit only closes the clock of slots that sit on that network
  assign periph_clock_net_off = st_r.ctrl.c0[`PMG_B_NET];
  assign nonvolatile_mem_off = mod_off[`PMG_M_NVM];

  // One reset-and-wake cell per slot; the memory slot waits longer than the rest
  genvar gi;
  generate
    for (gi = 0; gi < `PMG_NUM_MODS; gi++) begin : g_slot
      localparam int WAKE = (gi == `PMG_M_NVM) ? NVM_WAKE_CLKS : INSTR_CLKS;

      pmg_gate_cell #(
        .WAKE_CLKS(`PMG_WAKE_W'(WAKE))
      ) u_cell (
        .clk(clk),
        .srst(srst),
        .off(mod_off[gi]),
        .rst_hold(rst_hold[gi]),
        .active(live[gi])
      );

      // Clock stays open during wake so the held reset can take effect
      assign clk_open[gi] = !mod_off[gi] && !(SYSCLK_USERS[gi] && periph_clock_net_off); // RULE2 RULE9
      // Register writes reach only a live slot; a waking slot also refuses them
      assign sfr_ok[gi] = live[gi] && sfr_sel[gi]; // RULE4 RULE8
    end
  endgenerate

  // Outputs toward the slots
  always_comb begin
    mod_out.clk_en = clk_open;
    mod_out.rst = rst_hold; // RULE3
    mod_out.ctrl = mod_in.ctrl & ~mod_off & clk_open; // RULE2
    mod_out.aout_en = ~mod_off; // RULE5
    mod_out.sfr_wr = sfr_wr ? sfr_ok : '0; // RULE4
  end

  assign mod_active = live;

  // Register read mux over live slots only; anything else reads as zero
  always_comb begin
    sfr_mux = '0;
    for (int i = 0; i < `PMG_NUM_MODS; i++) begin
      if (sfr_ok[i]) begin
        sfr_mux = sfr_mux | mod_in.sfr_rdata[i]; // RULE4
      end
    end
  end

  // Indirect memory path: blocked while the memory slot is off or waking
  assign ee_rd = ee_rd_in && live[`PMG_M_NVM]; // RULE12
  assign ee_wr = ee_wr_in && live[`PMG_M_NVM]; // RULE12

  // Avalon decode; the control registers never sit behind any gate
  assign bus_req = avs_read || avs_write;
  assign hit_ctrl0 = (avs_address == `PMG_OFF_CTRL0);
  assign hit_ctrl1 = (avs_address == `PMG_OFF_CTRL1);
  assign hit_ctrl2 = (avs_address == `PMG_OFF_CTRL2);
  assign hit_stat = (avs_address == `PMG_OFF_STAT);
  assign hit_any = hit_ctrl0 || hit_ctrl1 || hit_ctrl2 || hit_stat;
  assign lane0_wr = avs_write && st_r.ack && avs_byteenable[0];

  // Every request waits exactly one cycle; cheaper than a decode path at 200 MHz
  assign avs_waitrequest = bus_req && !st_r.ack;

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = bus_req && !st_r.ack;

    // Writes take effect on the edge where waitrequest is seen low
    if (lane0_wr && hit_ctrl0) begin
      st_nxt.ctrl.c0 = avs_writedata[7:0] & `PMG_CTRL0_MASK; // RULE16 RULE17
    end
    if (lane0_wr && hit_ctrl1) begin
      st_nxt.ctrl.c1 = avs_writedata[7:0] & `PMG_CTRL1_MASK; // RULE17
    end
    if (lane0_wr && hit_ctrl2) begin
      st_nxt.ctrl.c2 = avs_writedata[7:0] & `PMG_CTRL2_MASK; // RULE16 RULE17
    end

    // Read data and response are set up in the waiting cycle
    if (bus_req && !st_r.ack) begin
      st_nxt.resp = hit_any ? `PMG_RESP_OKAY : `PMG_RESP_DECERR;
      st_nxt.rdata = '0;
      if (avs_read) begin
        unique case (1'b1)
          hit_ctrl0: st_nxt.rdata[7:0] = st_r.ctrl.c0 & `PMG_CTRL0_MASK; // RULE16
          hit_ctrl1: st_nxt.rdata[7:0] = st_r.ctrl.c1;
          hit_ctrl2: st_nxt.rdata[7:0] = st_r.ctrl.c2 & `PMG_CTRL2_MASK; // RULE16
          hit_stat: st_nxt.rdata[`PMG_NUM_MODS-1:0] = live;
          default: st_nxt.rdata = '0;
        endcase
      end
    end else if (!bus_req) begin
      st_nxt.rdata = '0;
      st_nxt.resp = `PMG_RESP_OKAY;
    end

    // Peripheral-side data outputs, registered and forced low while off
    st_nxt.sfr_rdata = sfr_rd ? sfr_mux : '0; // RULE4
    st_nxt.dout = mod_in.dout & ~mod_off; // RULE5
    st_nxt.ee_rdata = (ee_rd_in && live[`PMG_M_NVM]) ? ee_rdata_in : '0; // RULE12
  end

  // Registered state; srst clears the disable bits, as does a bus write of zero to them
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.ctrl <= '{c2: `PMG_CTRL_RST, c1: `PMG_CTRL_RST, c0: `PMG_CTRL_RST}; // RULE1 RULE17
    end else begin
      st_r <= st_nxt; // RULE18
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_response = st_r.resp;
  assign sfr_rdata = st_r.sfr_rdata;
  assign mod_dout = st_r.dout;
  assign ee_rdata = st_r.ee_rdata;

endmodule // pmg_top

// ---- test/pmg_slots_model.sv ----
// Behavioural gated peripherals: one counting register per slot.
// Assumes mod_out comes from the gate; answers on mod_in.
`timescale 1ns/1ps

module pmg_slots_model import pmg_pkg::*; (
  input wire logic clk,
  input wire pmg_mod_out_t mod_out,
  output pmg_mod_in_t mod_in
);
  logic [15:0][7:0] cnt_r;
  // Zero in reset, loaded by a register write, counting only while clocked
  always_ff @(posedge clk) begin
    for (int i = 0; i < 16; i++) begin
      if (mod_out.rst[i]) begin
        cnt_r[i] <= 8'h00;
      end else if (mod_out.sfr_wr[i]) begin
        cnt_r[i] <= 8'hA5;
      end else if (mod_out.clk_en[i]) begin
        cnt_r[i] <= cnt_r[i] + 8'h01;
      end
    end
  end
  // Outputs stay nonzero even in reset, so only the gate can force them low
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      mod_in.sfr_rdata[i] = cnt_r[i] | 8'h80;
      mod_in.dout[i] = ~cnt_r[i][1];
      mod_in.ctrl[i] = ~cnt_r[i][0];
    end
  end
endmodule // pmg_slots_model

// ---- test/pmg_top_assertions.sv ----
// Port checks on the gate, bound into every pmg_top.
// Assumes the bench sets the memory wake count to 4 cycles.
`timescale 1ns/1ps
`include "pmg_params.svh"

module pmg_top_assertions import pmg_pkg::*; #(
  parameter logic [`PMG_NUM_MODS-1:0] SYSCLK_USERS = `PMG_SYSCLK_USERS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`PMG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`PMG_BUS_W-1:0] avs_readdata,
  input wire logic [1:0] avs_response,
  input wire logic avs_waitrequest,
  input wire pmg_mod_out_t mod_out,
  input wire logic [`PMG_NUM_MODS-1:0] mod_dout,
  input wire logic [`PMG_NUM_MODS-1:0] mod_active,
  input wire logic periph_clock_net_off,
  input wire logic nonvolatile_mem_off,
  input wire logic ee_rd,
  input wire logic ee_wr
);
  localparam int NV = `PMG_M_NVM;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_wait_one:
  assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait");
  a_unmap_resp:
  assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |->
    avs_response == `PMG_RESP_DECERR && avs_readdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_unimp_zero:
  assert property (avs_read && !avs_waitrequest && avs_address == `PMG_OFF_CTRL0 |->
    (avs_readdata & 32'hFFFF_FF38) == 32'h0000_0000)
    else $error("unimplemented bits not zero");
  a_net_gate:
  assert property (periph_clock_net_off |-> (mod_out.clk_en & SYSCLK_USERS) == 16'h0000)
    else $error("clock net users still clocked");
  a_nvm_block:
  assert property (nonvolatile_mem_off |-> mod_out.rst[NV] &&
    !(mod_out.clk_en[NV] || mod_out.aout_en[NV] || mod_out.sfr_wr[NV] || ee_rd || ee_wr))
    else $error("memory slot not blocked");
  a_dout_low:
  assert property ($past(nonvolatile_mem_off) && nonvolatile_mem_off |-> !mod_dout[NV])
    else $error("disabled output not low");
  a_nvm_wake:
  assert property ($fell(nonvolatile_mem_off) |-> (mod_out.rst[NV] && !mod_active[NV]) [*4]
    ##1 (!mod_out.rst[NV] && mod_active[NV]))
    else $error("memory wake timing wrong");
  a_off_gate:
  assert property ((mod_out.sfr_wr & ~mod_out.aout_en) == 16'h0000 &&
    (mod_active & mod_out.rst) == 16'h0000 && (~mod_out.aout_en & ~mod_out.rst) == 16'h0000)
    else $error("disabled slot not gated");
endmodule // pmg_top_assertions

bind pmg_top pmg_top_assertions #(.SYSCLK_USERS(SYSCLK_USERS)) chk_u (.clk, .srst,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_response, .avs_waitrequest,
  .mod_out, .mod_dout, .mod_active, .periph_clock_net_off, .nonvolatile_mem_off,
  .ee_rd, .ee_wr);

// ---- test/tb_top.sv ----
// Self-checking bench for the peripheral module gate.
// Assumes the checker binds itself and the slot model sits on the far side.
`timescale 1ns/1ps
`include "pmg_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_top import pmg_pkg::*;;
  logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, ee_rd_in = 1'b1, ee_wr_in = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic [15:0] sfr_sel = 16'h0000, mod_dout, mod_active;
  logic [7:0] ee_rdata_in = 8'h5A, sfr_rdata, ee_rdata;
  logic [1:0] avs_response, r;
  logic avs_waitrequest, periph_clock_net_off, nonvolatile_mem_off, ee_rd, ee_wr;
  pmg_mod_in_t mod_in;
  pmg_mod_out_t mod_out;
  int n_errors = 0, cmp_count = 0, cycles = 0;

  // Short wake counts keep the run brief
  pmg_top #(.INSTR_CLKS(4), .NVM_WAKE_CLKS(4)) dut_u (.clk, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_response, .avs_waitrequest, .sfr_sel, .sfr_wr, .sfr_rd, .sfr_rdata,
    .mod_in, .mod_out, .mod_dout, .mod_active, .periph_clock_net_off, .ee_rd_in,
    .ee_wr_in, .ee_rdata_in, .ee_rd, .ee_wr, .ee_rdata, .nonvolatile_mem_off);
  pmg_slots_model slots_u (.clk, .mod_out, .mod_in);

  always #2.5 clk = ~clk;

  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // One access; the request stands until a rising edge sees waitrequest low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Reads back all three disable registers
  task automatic chk_regs(input logic [7:0] v);
    xfer(1'b0, `PMG_OFF_CTRL0, 8'h00);
    `CHK("ctrl0", {24'h00_0000, v & `PMG_CTRL0_MASK}, q)
    xfer(1'b0, `PMG_OFF_CTRL1, 8'h00);
    `CHK("ctrl1", {24'h00_0000, v & `PMG_CTRL1_MASK}, q)
    xfer(1'b0, `PMG_OFF_CTRL2, 8'h00);
    `CHK("ctrl2", {24'h00_0000, v & `PMG_CTRL2_MASK}, q)
  endtask

  // Control bit that disables slot i
  function automatic int bit_of(int i);
    if (i < 4) return (i == 3) ? 6 : i;
    if (i < 12) return i - 4;
    return (i < 14) ? i - 11 : i - 9;
  endfunction

  initial begin
    int a;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    chk_regs(8'h00);
    xfer(1'b0, 4'h2, 8'h00);
    `CHK("resp", `PMG_RESP_DECERR, r)
    sfr_rd <= 1'b1;
    sfr_wr <= 1'b1;
    // Each slot alone: off, checked, back on after one instruction
    for (int i = 0; i < 16; i++) begin
      a = (i < 4) ? 0 : (i < 12) ? 4 : 8;
      sfr_sel <= 16'h0001 << i;
      xfer(1'b1, 4'(a), 8'(1 << bit_of(i)));
      @(negedge clk);
      `CHK("rst", 16'h0001 << i, mod_out.rst)
      `CHK("aout_en", ~(16'h0001 << i), mod_out.aout_en)
      `CHK("clk_en", ~(16'h0001 << i), mod_out.clk_en)
      `CHK("ee_rd", 1'(i != 2), ee_rd)
      `CHK("sfr_wr_off", 16'h0000, mod_out.sfr_wr)
      @(negedge clk);
      `CHK("ctrl_off", 1'b0, mod_out.ctrl[i])
      `CHK("sfr_rdata", 8'h00, sfr_rdata)
      `CHK("dout", 1'b0, mod_dout[i])
      `CHK("ee_rdata", (i == 2) ? 8'h00 : 8'h5A, ee_rdata)
      xfer(1'b1, 4'(a), 8'h00);
      @(negedge clk);
      `CHK("waking", 1'b0, mod_active[i])
      `CHK("wake_rst", 1'b1, mod_out.rst[i])
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK("sfr_live", 8'hA5, sfr_rdata)
      `CHK("dout_live", 1'b1, mod_dout[i])
      `CHK("sfr_wr_live", 16'h0001 << i, mod_out.sfr_wr)
    end
    @(negedge clk);
    `CHK("active", 16'hFFFF, mod_active)
    xfer(1'b0, `PMG_OFF_STAT, 8'h00);
    `CHK("stat", 32'h0000_FFFF, q)
    xfer(1'b1, `PMG_OFF_CTRL0, 8'h80);
    @(negedge clk);
    `CHK("net_clk_en", ~`PMG_SYSCLK_USERS, mod_out.clk_en)
    `CHK("net_rst", 16'h0000, mod_out.rst)
    for (int k = 0; k < 3; k++) xfer(1'b1, 4'(k * 4), 8'hFF);
    chk_regs(8'hFF);
    avs_byteenable <= 4'hE;
    xfer(1'b1, `PMG_OFF_CTRL1, 8'h00);
    avs_byteenable <= 4'hF;
    xfer(1'b0, `PMG_OFF_CTRL1, 8'h00);
    `CHK("lane_off", 32'h0000_00FF, q)
    @(negedge clk);
    `CHK("all_rst", 16'hFFFF, mod_out.rst)
    `CHK("nvm_off", 1'b1, nonvolatile_mem_off)
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_regs(8'h00);
    print_verdict();
  end
endmodule // tb_top
